// *** dv/host_model.sv ***
// Purpose: Host side that writes control frames and pulses strobes.
// Assumes: Each task is entered just after a falling edge of clk_sys.
// Notes:   A released word shows the inverse of the last word sent.
`include "dac_state_defines.svh"

module host_model #(
    parameter int WORD_W = `CTRL_WORD_W
)(
    input wire logic clk_sys,
    output logic ctrl_wr_stb,
    output logic ctrl_frame_ok,
    output logic [WORD_W-1:0] ctrl_word,
    output logic soft_reset_stb,
    output logic dac_code_wr
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        ctrl_wr_stb = 1'b0;
        ctrl_frame_ok = 1'b0;
        ctrl_word = '0;
        soft_reset_stb = 1'b0;
        dac_code_wr = 1'b0;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // One frame held for one cycle; caller picks the state bits
    task automatic write_ctrl(input logic [WORD_W-1:0] word,
                              input logic ok);
        ctrl_word = word;
        ctrl_frame_ok = ok;
        ctrl_wr_stb = 1'b1;
        @(negedge clk_sys);
        ctrl_wr_stb = 1'b0;
        ctrl_frame_ok = 1'b0;
        ctrl_word = ~word;
    endtask : write_ctrl

    // Two frames on consecutive edges, strobe held high between them
    task automatic write_pair(input logic [WORD_W-1:0] w_a,
                              input logic [WORD_W-1:0] w_b);
        ctrl_word = w_a;
        ctrl_frame_ok = 1'b1;
        ctrl_wr_stb = 1'b1;
        @(negedge clk_sys);
        ctrl_word = w_b;
        @(negedge clk_sys);
        ctrl_wr_stb = 1'b0;
        ctrl_frame_ok = 1'b0;
        ctrl_word = ~w_b;
    endtask : write_pair

    // One-cycle pulse of either the reset bit or a code load;
    // only the chosen strobe is touched, so pulses may follow directly
    task automatic pulse(input logic code_load);
        if (code_load) begin
            dac_code_wr = 1'b1;
        end else begin
            soft_reset_stb = 1'b1;
        end
        @(negedge clk_sys);
        if (code_load) begin
            dac_code_wr = 1'b0;
        end else begin
            soft_reset_stb = 1'b0;
        end
    endtask : pulse

endmodule : host_model

// *** dv/tb_dac_output_state_control.sv ***
// Purpose: Self-checking bench of the output state control block.
// Assumes: Host drives on falling edges; outputs checked there too.
// Notes:   Frames land two edges after the strobe, pulses after one.
`include "dac_state_defines.svh"

module tb_dac_output_state_control
    import dac_state_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int WORD_W = `CTRL_WORD_W;
    logic clk_sys, sys_rst;
    wire logic wr_stb, frame_ok, soft_stb, code_wr;
    wire logic [WORD_W-1:0] word;
    logic iso, clamp, fsel, por, refc, amp, gnd, tri_o, par, negh;
    logic [3:0] lin;
    out_mode_t mode;
    int fails, n_tests;
    // Expected state kept by the bench
    logic e_iso, e_clamp, e_fsel, e_por, e_loaded, e_negh;
    logic [3:0] e_lin;
    wire logic [15:0] got = {iso, clamp, fsel, lin, mode, por, refc, amp,
        gnd, tri_o, par, negh};

    // ------------------------------------------------------------
    // Instances and clock
    // ------------------------------------------------------------
    host_model #(.WORD_W(WORD_W)) host_model_inst (.clk_sys(clk_sys),
        .ctrl_wr_stb(wr_stb), .ctrl_frame_ok(frame_ok),
        .ctrl_word(word), .soft_reset_stb(soft_stb),
        .dac_code_wr(code_wr));

    dac_output_state_control #(.WORD_W(WORD_W))
        dac_output_state_control_inst (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .ctrl_wr_stb(wr_stb), .ctrl_frame_ok(frame_ok),
        .ctrl_word(word), .soft_reset_stb(soft_stb),
        .dac_code_wr(code_wr), .core_isolate_bit(iso),
        .output_clamp_bit(clamp), .feedback_resistor_select(fsel),
        .lin_comp(lin), .out_mode(mode), .por_hold(por),
        .ref_connect(refc), .amp_out_en(amp), .ground_clamp_en(gnd),
        .output_tristate(tri_o), .parallel_fb_en(par),
        .neg_reference_hold(negh));

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    // All outputs worked out from the expected fields
    function automatic logic [15:0] exp_vec();
        out_mode_t m;
        m = e_clamp ? MODE_CLAMP : (e_iso ? MODE_TRI : MODE_NORMAL);
        // References are joined only in normal mode
        return {e_iso, e_clamp, e_fsel, e_lin, m, e_por, m == MODE_NORMAL,
            m == MODE_NORMAL, e_clamp, m == MODE_TRI, e_fsel, e_negh};
    endfunction : exp_vec

    // Builds a control word from its fields
    function automatic logic [WORD_W-1:0] cw(input logic i, input logic c,
                                             input logic r,
                                             input logic [3:0] l);
        logic [WORD_W-1:0] w;
        w = '0;
        w[`ISO_POS] = i;
        w[`CLAMP_POS] = c;
        w[`FB_SEL_POS] = r;
        w[`LIN_HI:`LIN_LO] = l;
        return w;
    endfunction : cw

    // Power-on expectation
    task automatic por_exp();
        {e_iso, e_clamp, e_fsel, e_lin} = {1'b1, 1'b1, 1'b0, 4'h0};
        {e_por, e_loaded, e_negh} = 3'b100;
    endtask : por_exp

    // Effect of an accepted frame on the expectation
    task automatic apply(input logic [WORD_W-1:0] w);
        e_iso = w[`ISO_POS];
        e_clamp = w[`CLAMP_POS];
        e_fsel = w[`FB_SEL_POS];
        e_lin = w[`LIN_HI:`LIN_LO];
        e_por = e_por & e_iso & e_clamp;
        e_negh = ~e_iso & ~e_clamp & ~e_loaded;
    endtask : apply

    // Compares all outputs with the expectation
    task automatic check(input string msg);
        n_tests++;
        if (got !== exp_vec()) begin
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time,
                msg, got, exp_vec());
            fails++;
        end
    endtask : check

    // Frame, old values after first edge, new after second
    task automatic wr(input logic [WORD_W-1:0] w, input logic ok);
        host_model_inst.write_ctrl(w, ok);
        check("early change");
        @(negedge clk_sys);
        if (ok) begin
            apply(w);
        end
        check("frame result");
    endtask : wr

    // Prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        fails = 0;
        n_tests = 0;
        por_exp();
        repeat (6) @(negedge clk_sys);
        check("in reset");
        sys_rst = 1'b0;
        @(negedge clk_sys);
        check("after reset");
        wr(cw(1'b0, 1'b0, 1'b1, 4'h0), 1'b0);
        wr(cw(1'b1, 1'b1, 1'b0, 4'hc), 1'b1);
        // Every state code, select bit toggling, intermediate codes
        for (int i = 0; i < 4; i++) begin
            wr(cw(i[1], i[0], i[0], 4'h5 + i[3:0]),
               1'b1);
        end
        wr(cw(1'b0, 1'b0, 1'b0, 4'h0), 1'b1);
        host_model_inst.pulse(1'b1);
        {e_loaded, e_negh} = 2'b10;
        check("code load");
        host_model_inst.pulse(1'b0);
        por_exp();
        check("soft reset");
        // Reset bit in the cycle after a frame discards the frame
        host_model_inst.write_ctrl(cw(1'b0, 1'b0, 1'b1, 4'hc), 1'b1);
        host_model_inst.pulse(1'b0);
        check("reset over frame");
        @(negedge clk_sys);
        check("frame discarded");
        // Code loaded before leaving the power-on state
        host_model_inst.pulse(1'b1);
        e_loaded = 1'b1;
        check("early load");
        wr(cw(1'b0, 1'b0, 1'b0, 4'h0), 1'b1);
        // Back to back frames, strobe held high across both
        fork
            host_model_inst.write_pair(cw(1'b1, 1'b0, 1'b1, 4'h3),
                cw(1'b0, 1'b1, 1'b0, 4'h9));
            begin
                @(negedge clk_sys);
                check("first pending");
            end
        join
        apply(cw(1'b1, 1'b0, 1'b1, 4'h3));
        check("first landed");
        @(negedge clk_sys);
        apply(cw(1'b0, 1'b1, 1'b0, 4'h9));
        check("second landed");
        // Reset again in mid-run
        sys_rst = 1'b1;
        @(negedge clk_sys);
        por_exp();
        check("second reset");
        sys_rst = 1'b0;
        @(negedge clk_sys);
        check("after second reset");
        give_verdict();
    end

endmodule : tb_dac_output_state_control

// *** logic/ctrl_fields_if.sv ***
// Purpose: Carries held control fields and decoded mode between modules.
// Assumes: One holder, one decoder, one consumer.
// Notes:   applied is a one-cycle pulse per accepted frame.
interface ctrl_fields_if;
    import dac_state_pkg::*;
    ctrl_fields_t fields; // Held control fields
    logic applied; // Pulse: fields just loaded
    out_mode_t mode; // Decoded output state
    modport holder(output fields, output applied);
    modport decoder(input fields, output mode);
    modport top(input fields, input applied, input mode);
endinterface : ctrl_fields_if

// *** logic/ctrl_reg_hold.sv ***
// Purpose: Holds control fields, loading them only on a valid frame.
// Assumes: Strobes come from logic on clk_sys.
// Notes:   Software reset beats a write in the same cycle.
`include "dac_state_defines.svh"

module ctrl_reg_hold
    import dac_state_pkg::*;
#(
    parameter int WORD_W = `CTRL_WORD_W
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_stb,
    input wire logic frame_ok,
    input wire logic soft_rst,
    input wire logic [WORD_W-1:0] wr_word,
    ctrl_fields_if.holder bus
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WORD_W <= `LIN_HI) begin : g_bad_w
        $error("Control word too narrow for the compensation field");
    end

    hold_state_t r_reg; // Registered state
    hold_state_t r_next; // Next state

    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.applied = 1'b0;
        if (soft_rst) begin
            // Back to power-on values
            r_next.f = FIELDS_RST;
        end else if (wr_stb && frame_ok) begin
            // Only a complete, valid frame is taken
            r_next.f.iso = wr_word[`ISO_POS];
            r_next.f.clamp = wr_word[`CLAMP_POS];
            r_next.f.fb_sel = wr_word[`FB_SEL_POS];
            r_next.f.lin = wr_word[`LIN_HI:`LIN_LO];
            r_next.applied = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '{f: FIELDS_RST, applied: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.fields = r_reg.f;
    assign bus.applied = r_reg.applied;

endmodule : ctrl_reg_hold

// *** logic/dac_output_state_control.sv ***
// Purpose: Output state control of a voltage-output converter.
// Assumes: Write strobes come from the serial front end on clk_sys.
// Notes:   Output states change two edges after a valid frame strobe.
//
// What this block does
// - Power-on reset restores every default value
// - Power-on: core isolated, output clamped
// - Power-on state holds until new bits
// - Entering normal mode gives negative reference unless loaded
// - Both bits zero means normal operation
// - Isolate only leaves output tristate
// - Clamp bit set always clamps output
// - Compensation field at bits nine to six
// - Compensation field resets to 0000
// - Select bit joins feedback resistors parallel
// - Isolate bit defaults to one
// - Software reset bit restores power-on state
`include "dac_state_defines.svh"

module dac_output_state_control
    import dac_state_pkg::*;
#(
    parameter int WORD_W = `CTRL_WORD_W
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ctrl_wr_stb,
    input wire logic ctrl_frame_ok,
    input wire logic [WORD_W-1:0] ctrl_word,
    input wire logic soft_reset_stb,
    input wire logic dac_code_wr,
    output logic core_isolate_bit,
    output logic output_clamp_bit,
    output logic feedback_resistor_select,
    output logic [`LIN_W-1:0] lin_comp,
    output out_mode_t out_mode,
    output logic por_hold,
    output logic ref_connect,
    output logic amp_out_en,
    output logic ground_clamp_en,
    output logic output_tristate,
    output logic parallel_fb_en,
    output logic neg_reference_hold
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WORD_W <= `LIN_HI) begin : g_bad_w
        $error("Control word too narrow for the compensation field");
    end

    // ------------------------------------------------------------
    // Field capture and decode
    // ------------------------------------------------------------
    ctrl_fields_if ctl_bus (); // Held fields and decoded mode

    // Captures fields from each valid frame
    ctrl_reg_hold #(
        .WORD_W(WORD_W)
    ) u_hold (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_stb(ctrl_wr_stb),
        .frame_ok(ctrl_frame_ok),
        .soft_rst(soft_reset_stb),
        .wr_word(ctrl_word),
        .bus(ctl_bus.holder)
    );

    // Turns isolate and clamp into an output mode
    out_mode_decode u_dec (
        .bus(ctl_bus.decoder)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam top_state_t TOP_RST = '{
        st: ST_POR,
        f: FIELDS_RST,
        mode: MODE_CLAMP,
        por: 1'b1,
        loaded: 1'b0,
        neg_hold: 1'b0,
        ref_conn: 1'b0,
        amp_en: 1'b0,
        gnd_en: 1'b1,
        tri_en: 1'b0,
        par_fb: 1'b0
    };

    top_state_t r_reg; // Registered state
    top_state_t r_next; // Next state

    // Next-state logic
    always_comb begin
        r_next = r_reg;
        // Remember that a converter code was loaded
        if (dac_code_wr) begin
            r_next.loaded = 1'b1;
            r_next.neg_hold = 1'b0;
        end
        if (ctl_bus.applied) begin
            r_next.f = ctl_bus.fields;
            r_next.mode = ctl_bus.mode;
            if (r_reg.st == ST_POR && ctl_bus.fields.iso
                && ctl_bus.fields.clamp) begin
                // Same state bits: stay in power-on hold
                r_next.st = ST_POR;
            end else begin
                unique case (ctl_bus.mode)
                    MODE_NORMAL: begin
                        r_next.st = ST_RUN;
                    end
                    MODE_TRI: begin
                        r_next.st = ST_TRI;
                    end
                    MODE_CLAMP: begin
                        r_next.st = ST_GND;
                    end
                    default: begin
                        // Illegal mode code: park safely
                        r_next.st = ST_GND;
                    end
                endcase
            end
            // Entering normal mode with no code loaded
            if (r_next.st == ST_RUN && r_reg.st != ST_RUN) begin
                r_next.neg_hold = !r_next.loaded;
            end
        end
        // Negative-reference hold only exists in normal mode
        if (r_next.st != ST_RUN) begin
            r_next.neg_hold = 1'b0;
        end
        // Analog switch controls follow the state
        r_next.por = (r_next.st == ST_POR);
        r_next.ref_conn = (r_next.st == ST_RUN);
        r_next.amp_en = (r_next.st == ST_RUN);
        r_next.gnd_en = (r_next.st == ST_POR)
                        || (r_next.st == ST_GND);
        r_next.tri_en = (r_next.st == ST_TRI);
        r_next.par_fb = r_next.f.fb_sel;
        // Software reset: back to power-on state
        if (soft_reset_stb) begin
            r_next = TOP_RST;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= TOP_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign core_isolate_bit = r_reg.f.iso;
    assign output_clamp_bit = r_reg.f.clamp;
    assign feedback_resistor_select = r_reg.f.fb_sel;
    assign lin_comp = r_reg.f.lin;
    assign out_mode = r_reg.mode;
    assign por_hold = r_reg.por;
    assign ref_connect = r_reg.ref_conn;
    assign amp_out_en = r_reg.amp_en;
    assign ground_clamp_en = r_reg.gnd_en;
    assign output_tristate = r_reg.tri_en;
    assign parallel_fb_en = r_reg.par_fb;
    assign neg_reference_hold = r_reg.neg_hold;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb_clk @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    logic wr_ok; // Valid frame not overridden by reset
    assign wr_ok = ctrl_wr_stb && ctrl_frame_ok && !soft_reset_stb;

    // Valid frame with given state bits, no reset behind it
    sequence frame_in(bit i, bit c);
        wr_ok && ctrl_word[`ISO_POS] == i
        && ctrl_word[`CLAMP_POS] == c ##1 !soft_reset_stb;
    endsequence

    // Any valid frame, no reset behind it
    sequence any_frame;
        wr_ok ##1 !soft_reset_stb;
    endsequence

    // Power-on hold: isolated and clamped
    por_clamp_a:
    assert property (por_hold |-> core_isolate_bit && ground_clamp_en
                     && !ref_connect && !output_tristate)
    else $error("Power-on hold not isolated and clamped");

    // Hold persists without a new frame
    por_persist_a:
    assert property (por_hold && !$past(wr_ok) && !wr_ok
                     |=> por_hold)
    else $error("Power-on hold left without a frame");

    // Both bits clear gives normal operation
    mode_normal_a:
    assert property (frame_in(1'b0, 1'b0) |=> out_mode == MODE_NORMAL
                     && ref_connect && amp_out_en && !ground_clamp_en)
    else $error("Normal mode not entered");

    // Isolate only gives tristate
    mode_tri_a:
    assert property (frame_in(1'b1, 1'b0) |=> output_tristate
                     && !ground_clamp_en && !ref_connect)
    else $error("Tristate not entered");

    // Clamp bit always clamps
    mode_clamp_a:
    assert property (wr_ok && ctrl_word[`CLAMP_POS] ##1 !soft_reset_stb
                     |=> ground_clamp_en && !output_tristate
                     && !amp_out_en)
    else $error("Clamp not applied");

    // Fresh normal mode shows negative reference if nothing loaded
    neg_ref_a:
    assert property (!$past(amp_out_en) && amp_out_en
                     && !$past(r_reg.loaded) && !$past(dac_code_wr)
                     |-> neg_reference_hold)
    else $error("Negative reference not held");

    // Compensation field follows the frame two edges later
    lin_field_a:
    assert property (any_frame |=> lin_comp
                     == $past(ctrl_word[`LIN_HI:`LIN_LO], 2))
    else $error("Compensation field not captured");

    // Select bit joins the resistors
    fb_select_a:
    assert property (wr_ok && ctrl_word[`FB_SEL_POS] ##1 !soft_reset_stb
                     |=> feedback_resistor_select && parallel_fb_en)
    else $error("Feedback resistors not joined");

    // Software reset restores power-on values
    soft_reset_a:
    assert property (soft_reset_stb |=> por_hold && core_isolate_bit
                     && output_clamp_bit && lin_comp == `LIN_RST
                     && !parallel_fb_en)
    else $error("Software reset did not restore power-on state");

    // Mode, compensation field and ground clamp change only after a frame or reset
    frame_only_a:
    assert property (!$past(wr_ok) && !soft_reset_stb
                     |=> $stable(out_mode) && $stable(lin_comp)
                     && $stable(ground_clamp_en))
    else $error("Output state changed without a frame");

    // ------------------------------------------------------------
    // Power-on values and output state consistency
    // ------------------------------------------------------------
    // Registers hold defaults at the first edge after reset
    reset_default_a:
    assert property ($fell(sys_rst) |-> por_hold && output_clamp_bit
                     && !feedback_resistor_select && !neg_reference_hold)
    else $error("Defaults missing after reset");

    // Compensation field comes out of reset at zero
    lin_reset_a:
    assert property ($fell(sys_rst) |-> lin_comp == `LIN_RST)
    else $error("Compensation field not reset");

    // Isolate bit comes out of reset set
    iso_default_a:
    assert property ($fell(sys_rst) |-> core_isolate_bit)
    else $error("Isolate bit not set after reset");

    // Exactly one of drive, clamp and tristate at a time
    one_state_a:
    assert property ($onehot({amp_out_en, ground_clamp_en,
                              output_tristate}))
    else $error("Output stage in more than one state");

    // References joined only with both state bits clear
    ref_bits_a:
    assert property (ref_connect |-> !core_isolate_bit
                     && !output_clamp_bit)
    else $error("References joined while isolated or clamped");

    // Tristate only with isolate set and clamp clear
    tri_bits_a:
    assert property (output_tristate |-> core_isolate_bit
                     && !output_clamp_bit)
    else $error("Tristate with wrong state bits");

    // Negative-reference hold only while driving
    neg_run_a:
    assert property (neg_reference_hold |-> amp_out_en)
    else $error("Negative reference held outside normal mode");

    // A loaded code ends the negative-reference hold
    code_clear_a:
    assert property (dac_code_wr |=> !neg_reference_hold)
    else $error("Code load did not end negative reference hold");

endmodule : dac_output_state_control

// *** logic/dac_state_defines.svh ***
// Purpose: Shared field positions, reset values and widths.
// Assumes: Control word bits are numbered from the LSB of the data field.
// Notes:   Definitions only; included by bare name.
`ifndef DAC_STATE_DEFINES_SVH
`define DAC_STATE_DEFINES_SVH

// ----------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------
`define CTRL_WORD_W 20
`define FB_SEL_POS 1
`define CLAMP_POS 2
`define ISO_POS 3
`define LIN_HI 9
`define LIN_LO 6
`define LIN_W 4

// ----------------------------------------------------------------
// Power-on values
// ----------------------------------------------------------------
`define ISO_RST 1'b1
`define CLAMP_RST 1'b1
`define FB_SEL_RST 1'b0
`define LIN_RST 4'h0

`endif

// *** logic/dac_state_pkg.sv ***
// Purpose: Types and the output-state decode shared by the block.
// Assumes: dac_state_defines.svh supplies widths and reset values.
// Notes:   State structs of every module live here.
`include "dac_state_defines.svh"

package dac_state_pkg;

    // Output state selected by isolate and clamp bits
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_CLAMP = 2'b01,
        MODE_TRI = 2'b10
    } out_mode_t;

    // Sequencing state of the output stage
    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_RUN = 2'b01,
        ST_TRI = 2'b10,
        ST_GND = 2'b11
    } ctl_state_t;

    // Control fields held from the last valid frame
    typedef struct packed {
        logic iso;
        logic clamp;
        logic fb_sel;
        logic [`LIN_W-1:0] lin;
    } ctrl_fields_t;

    // Whole state of the capture module
    typedef struct packed {
        ctrl_fields_t f;
        logic applied;
    } hold_state_t;

    // Whole state of the top module
    typedef struct packed {
        ctl_state_t st;
        ctrl_fields_t f;
        out_mode_t mode;
        logic por;
        logic loaded;
        logic neg_hold;
        logic ref_conn;
        logic amp_en;
        logic gnd_en;
        logic tri_en;
        logic par_fb;
    } top_state_t;

    localparam ctrl_fields_t FIELDS_RST = '{
        iso: `ISO_RST, clamp: `CLAMP_RST, fb_sel: `FB_SEL_RST,
        lin: `LIN_RST};

    // Clamp dominates, then isolation, else normal
    function automatic out_mode_t decode_mode(input logic iso,
                                              input logic clamp);
        out_mode_t m;
        m = MODE_NORMAL;
        if (clamp) begin
            m = MODE_CLAMP;
        end else if (iso) begin
            m = MODE_TRI;
        end
        return m;
    endfunction : decode_mode

endpackage : dac_state_pkg

// *** logic/out_mode_decode.sv ***
// Purpose: Decodes the output state from isolate and clamp fields.
// Assumes: Fields are registered upstream.
// Notes:   Pure decode, no state.
module out_mode_decode
    import dac_state_pkg::*;
(
    ctrl_fields_if.decoder bus
);

    // Clamp wins over isolation
    assign bus.mode = decode_mode(bus.fields.iso, bus.fields.clamp);

endmodule : out_mode_decode
